// file: verilog/sbs_supervisor.sv
// Supervisory logic: modes, reset/interrupt/watchdog pins, serial port, APB
`timescale 1ns/1ps
`default_nettype none
`include "sbs_consts.svh"
module sbs_supervisor #(
  parameter int unsigned NREQ_CYCLES = int'(`SBS_NREQ_CYCLES),
  parameter int unsigned RST_DUR_CYCLES = 40000,
  parameter int unsigned WD_PERIOD_CYCLES = 4000000,
  parameter int unsigned CYC_PERIOD_CYCLES = 800000,
  parameter int unsigned CYC_ON_CYCLES = 800
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial port pins
  input wire logic sclk,
  input wire logic chipSelN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  // Bus transceiver data path
  input wire logic txData,
  output logic rxData,
  input wire logic busDominantIn,
  output logic busDriveDominant,
  output logic canWakeOnly,
  // Analog indications and wake inputs
  input wire sbs_pkg::sbs_analog_s analogIn,
  input wire logic [3:0] level_inputs,
  // Supervisor outputs
  output logic resetOutN,
  output logic intOutN,
  output logic watchdog_fault_out_n,
  output logic mainRegEnable,
  output logic secondary_reg_drive,
  output logic high_side_switch,
  output logic lowPowerOscSel
);
  localparam int unsigned PULSE_CYCLES = int'(`SBS_WAKE_PULSE_CYCLES);
  localparam int SYW = 16;

  // Two-flop synchronisers; stage one feeds only stage two
  logic [SYW-1:0] syncA;
  logic [SYW-1:0] syncB;
  logic [SYW-1:0] syncC;
  always_ff @(posedge ref_clk)
  begin
    syncA <= {sclk, chipSelN, mosi, txData, busDominantIn, level_inputs,
      analogIn};
    syncB <= syncA;
    syncC <= syncB;
  end

  logic sclkS;
  logic csS;
  logic mosiS;
  logic txS;
  logic busS;
  logic [3:0] levelS;
  sbs_pkg::sbs_analog_s ana;
  assign {sclkS, csS, mosiS, txS, busS, levelS, ana} = syncB;
  logic sclkFall;
  logic sclkRise;
  logic csRise;
  logic levelEdge;
  assign sclkFall = syncC[15] & ~sclkS;
  assign sclkRise = ~syncC[15] & sclkS;
  assign csRise = ~syncC[14] & csS;
  assign levelEdge = |(syncC[10:7] ^ levelS);

  // Mode helpers used in several places
  function automatic logic isRun(input sbs_pkg::sbs_mode_e m);
    return (m == sbs_pkg::MODE_NORMAL) || (m == sbs_pkg::MODE_STANDBY);
  endfunction
  function automatic logic isLow(input sbs_pkg::sbs_mode_e m);
    return (m == sbs_pkg::MODE_STOP) || (m == sbs_pkg::MODE_SLEEP);
  endfunction

  // Serial shifter: mosi taken on falling, miso moved on rising edge
  logic [7:0] spiIn;
  logic [7:0] spiOut;
  logic [3:0] spiCnt;
  logic [4:0] intFlags;
  logic [3:0] intEnable;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      spiIn <= 8'h00;
      spiOut <= 8'h00;
      spiCnt <= 4'h0;
      miso <= 1'b0;
      misoOe <= 1'b0;
    end
    else
    begin
      misoOe <= ~csS;
      if (csS)
      begin
        // Status byte preloaded while idle, battery fail flag waits on miso ahead of it
        spiCnt <= 4'h0;
        spiOut <= {intFlags[3:0], ana.battery_fail_flag, ana.secLow, ana.hsOt,
          ana.batLow};
        miso <= intFlags[`SBS_FLG_BATTERY_FAIL_FLAG];
      end
      else
      begin
        if (sclkFall)
        begin
          spiIn <= {spiIn[6:0], mosiS};
          spiCnt <= spiCnt + 4'h1;
        end
        if (sclkRise)
        begin
          miso <= spiOut[7];
          spiOut <= {spiOut[6:0], 1'b0};
        end
      end
    end
  end

  // Commit a whole frame at chip select release; short frames dropped
  sbs_pkg::sbs_cmd_s spiCmd;
  assign spiCmd.valid = csRise && (spiCnt == `SBS_SPI_BITS) && spiIn[4];
  assign spiCmd.sel = spiIn[7:5];
  assign spiCmd.data = spiIn[3:0];

  // APB decode, zero wait states, answer prepared in setup cycle
  logic apbAccess;
  logic apbWrite;
  logic mapped;
  assign apbAccess = psel & penable & pready;
  assign apbWrite = apbAccess & pwrite & ~pslverr;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `SBS_OFS_INT_FLAGS);
  sbs_pkg::sbs_cmd_s apbCmd;
  assign apbCmd.valid = apbWrite && (paddr < `SBS_OFS_IO_STATUS);
  assign apbCmd.sel = paddr[4:2];
  assign apbCmd.data = pwdata[3:0];
  sbs_pkg::sbs_cmd_s cmd;
  assign cmd = spiCmd.valid ? spiCmd : apbCmd;
  logic [4:0] flagClr;
  assign flagClr = (apbWrite && paddr == `SBS_OFS_INT_FLAGS) ?
    pwdata[4:0] : 5'h00;

  sbs_pkg::sbs_mode_e mode;
  logic [1:0] hsCtrl;
  logic wdTarget;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && mapped)
      begin
        unique case (paddr)
          `SBS_OFS_MODE_CMD: prdata <= {25'h0, ana.tempWarn, mode};
          `SBS_OFS_WD_CONFIG: prdata <= {31'h0, wdTarget};
          `SBS_OFS_INT_ENABLE: prdata <= {28'h0, intEnable};
          `SBS_OFS_HS_CTRL: prdata <= {30'h0, hsCtrl};
          `SBS_OFS_IO_STATUS: prdata <= {24'h0, levelS, ana.batLow,
            ana.secLow, ana.hsOt, ana.battery_fail_flag};
          default: prdata <= {27'h0, intFlags};
        endcase
      end
    end
  end

  // Control registers written from either port
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      intEnable <= `SBS_RST_INT_ENABLE;
      hsCtrl <= `SBS_RST_HS_CTRL;
    end
    else if (cmd.valid && cmd.sel == `SBS_CMD_INTEN)
      intEnable <= cmd.data;
    else if (cmd.valid && cmd.sel == `SBS_CMD_HS)
      hsCtrl <= cmd.data[1:0];
  end

  // Sticky flags; a new event outranks a clear in the same cycle
  logic [4:0] flagSet;
  logic wakeEv;
  always_comb
  begin
    flagSet = 5'h00;
    flagSet[`SBS_FLG_TEMP] = ana.tempWarn;
    flagSet[`SBS_FLG_BATLOW] = ana.batLow && isRun(mode);
    flagSet[`SBS_FLG_HSSEC] = ana.hsOt | ana.secLow;
    flagSet[`SBS_FLG_WAKE] = wakeEv;
    flagSet[`SBS_FLG_BATTERY_FAIL_FLAG] = ana.battery_fail_flag;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      intFlags <= 5'h00;
    else
      intFlags <= (intFlags & ~flagClr) | flagSet;
  end

  // Wake sources: level edges in sleep/stop, chip select release in stop
  assign wakeEv = (isLow(mode) && levelEdge) ||
    (mode == sbs_pkg::MODE_STOP && csRise);

  // Mode machine with its shared timer
  logic [31:0] timer;
  logic fromSleep;
  logic wdConfigWr;
  logic modeWr;
  assign wdConfigWr = cmd.valid && cmd.sel == `SBS_CMD_WD;
  assign modeWr = cmd.valid && cmd.sel == `SBS_CMD_MODE;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode <= sbs_pkg::MODE_RESET;
      timer <= 32'h0000_0000;
      fromSleep <= 1'b0;
      wdTarget <= 1'b0;
      watchdog_fault_out_n <= 1'b1;
    end
    else if (ana.mainUv && mode != sbs_pkg::MODE_SLEEP)
    begin
      mode <= sbs_pkg::MODE_RESET;
      timer <= 32'h0000_0000;
    end
    else
    begin
      timer <= timer + 32'h1;
      unique case (mode)
        sbs_pkg::MODE_RESET:
          if (timer >= RST_DUR_CYCLES - 1)
          begin
            mode <= sbs_pkg::MODE_NREQ;
            timer <= 32'h0000_0000;
          end
        sbs_pkg::MODE_NREQ:
          if (wdConfigWr)
          begin
            // Configuration arrived in time: leave for chosen run mode
            wdTarget <= cmd.data[0];
            watchdog_fault_out_n <= 1'b1;
            fromSleep <= 1'b0;
            mode <= cmd.data[0] ? sbs_pkg::MODE_STANDBY :
              sbs_pkg::MODE_NORMAL;
            timer <= 32'h0000_0000;
          end
          else if (timer >= NREQ_CYCLES - 1)
          begin
            mode <= fromSleep ? sbs_pkg::MODE_SLEEP :
              sbs_pkg::MODE_RESET;
            timer <= 32'h0000_0000;
          end
        sbs_pkg::MODE_NORMAL, sbs_pkg::MODE_STANDBY:
          if (wdConfigWr)
            timer <= 32'h0000_0000;
          else if (timer >= WD_PERIOD_CYCLES - 1)
          begin
            watchdog_fault_out_n <= 1'b0;
            mode <= sbs_pkg::MODE_RESET;
            timer <= 32'h0000_0000;
          end
          else if (modeWr)
          begin
            timer <= 32'h0000_0000;
            unique case (cmd.data)
              `SBS_REQ_NORMAL: mode <= sbs_pkg::MODE_NORMAL;
              `SBS_REQ_STANDBY: mode <= sbs_pkg::MODE_STANDBY;
              `SBS_REQ_STOP: mode <= sbs_pkg::MODE_STOP;
              `SBS_REQ_SLEEP: mode <= sbs_pkg::MODE_SLEEP;
              default: timer <= timer + 32'h1;
            endcase
          end
        sbs_pkg::MODE_STOP:
          if (wakeEv)
          begin
            mode <= sbs_pkg::MODE_NREQ;
            timer <= 32'h0000_0000;
          end
        default:
          if (wakeEv)
          begin
            // Sleep wake passes through reset since regulator was off
            fromSleep <= 1'b1;
            mode <= sbs_pkg::MODE_RESET;
            timer <= 32'h0000_0000;
          end
      endcase
    end
  end

  // Interrupt pin: level from enabled flags, pulse for stop-mode wake
  logic [15:0] pulseCnt;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pulseCnt <= 16'h0000;
      intOutN <= 1'b1;
    end
    else
    begin
      if (mode == sbs_pkg::MODE_STOP && wakeEv)
        pulseCnt <= PULSE_CYCLES[15:0];
      else if (pulseCnt != 16'h0000)
        pulseCnt <= pulseCnt - 16'h0001;
      intOutN <= ~((pulseCnt != 16'h0000) ||
        (isRun(mode) && |(intFlags[3:0] & intEnable)));
    end
  end

  // Cyclic timer for the high-side switch in low-power modes
  logic [31:0] cycCnt;
  always_ff @(posedge ref_clk)
  begin
    if (rst || !isLow(mode))
      cycCnt <= 32'h0000_0000;
    else if (cycCnt >= CYC_PERIOD_CYCLES - 1)
      cycCnt <= 32'h0000_0000;
    else
      cycCnt <= cycCnt + 32'h1;
  end

  // Pin outputs, all registered
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      resetOutN <= 1'b0;
      rxData <= 1'b1;
      busDriveDominant <= 1'b0;
      canWakeOnly <= 1'b1;
      mainRegEnable <= 1'b0;
      secondary_reg_drive <= 1'b0;
      high_side_switch <= 1'b0;
      lowPowerOscSel <= 1'b0;
    end
    else
    begin
      resetOutN <= (mode != sbs_pkg::MODE_RESET) && !ana.mainUv;
      rxData <= ~busS;
      // Transmit path only live in normal; elsewhere bus left recessive
      busDriveDominant <= (mode == sbs_pkg::MODE_NORMAL) && !txS;
      canWakeOnly <= mode != sbs_pkg::MODE_NORMAL;
      mainRegEnable <= (mode != sbs_pkg::MODE_SLEEP) && !ana.tempShut;
      secondary_reg_drive <= mode == sbs_pkg::MODE_NORMAL;
      high_side_switch <= isRun(mode) ? hsCtrl[0] :
        (isLow(mode) && hsCtrl[1] && cycCnt < CYC_ON_CYCLES);
      lowPowerOscSel <= isLow(mode);
    end
  end
endmodule
`default_nettype wire

// file: verilog/sbs_consts.svh
// Constants of the system basis supervisor: offsets, fields, resets, times
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
// APB byte offsets
`define SBS_OFS_MODE_CMD 12'h000
`define SBS_OFS_WD_CONFIG 12'h004
`define SBS_OFS_INT_ENABLE 12'h008
`define SBS_OFS_HS_CTRL 12'h00C
`define SBS_OFS_IO_STATUS 12'h010
`define SBS_OFS_INT_FLAGS 12'h014
// Command codes carried in the register-select field
`define SBS_CMD_MODE 3'h0
`define SBS_CMD_WD 3'h1
`define SBS_CMD_INTEN 3'h2
`define SBS_CMD_HS 3'h3
// Mode request codes
`define SBS_REQ_NORMAL 4'h0
`define SBS_REQ_STANDBY 4'h1
`define SBS_REQ_STOP 4'h2
`define SBS_REQ_SLEEP 4'h3
// Interrupt flag positions
`define SBS_FLG_TEMP 0
`define SBS_FLG_BATLOW 1
`define SBS_FLG_HSSEC 2
`define SBS_FLG_WAKE 3
`define SBS_FLG_BATTERY_FAIL_FLAG 4
// Reset values
`define SBS_RST_INT_ENABLE 4'h0
`define SBS_RST_HS_CTRL 2'h0
// Timing
`define SBS_CLK_HZ 64'd40000000
`define SBS_NREQ_TIME_MS 64'd350
`define SBS_NREQ_CYCLES (`SBS_NREQ_TIME_MS * `SBS_CLK_HZ / 64'd1000)
`define SBS_WAKE_PULSE_US 64'd10
`define SBS_WAKE_PULSE_CYCLES (`SBS_WAKE_PULSE_US * `SBS_CLK_HZ / 64'd1000000)
`define SBS_SPI_BITS 4'd8
`endif

// file: verilog/sbs_pkg.sv
// Types of the system basis supervisor
`default_nettype none
package sbs_pkg;
  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_RESET = 6'b000001,
    MODE_NREQ = 6'b000010,
    MODE_NORMAL = 6'b000100,
    MODE_STANDBY = 6'b001000,
    MODE_STOP = 6'b010000,
    MODE_SLEEP = 6'b100000
  } sbs_mode_e;
  // Analog supervisor indications
  typedef struct packed {
    logic mainUv;
    logic tempWarn;
    logic tempShut;
    logic battery_fail_flag;
    logic batLow;
    logic secLow;
    logic hsOt;
  } sbs_analog_s;
  // One register write from either port
  typedef struct packed {
    logic valid;
    logic [2:0] sel;
    logic [3:0] data;
  } sbs_cmd_s;
endpackage
`default_nettype wire

// file: tb/sbs_chk.sv
// Port checker of the supervisor, bound into its top module
`timescale 1ns/1ps
`default_nettype none
module sbs_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Serial and bus pins
  input wire logic chipSelN,
  input wire logic misoOe,
  input wire logic txData,
  input wire logic busDominantIn,
  input wire logic rxData,
  input wire logic busDriveDominant,
  input wire logic canWakeOnly,
  // Supply side
  input wire sbs_pkg::sbs_analog_s analogIn,
  input wire logic resetOutN,
  input wire logic mainRegEnable,
  input wire logic secondary_reg_drive,
  input wire logic lowPowerOscSel
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Bus cycle steps
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  // Zero-wait answer, so the host never stalls
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  apb_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  apb_refuse_a: assert property (access_s ##0 (paddr > 12'h014)
    |-> pslverr) else $error("unmapped address accepted");
  // Pins go through a three stage path, so five samples are enough
  rx_dom_a: assert property (busDominantIn [*5] |-> !rxData)
    else $error("receive not low on dominant bus");
  rx_rec_a: assert property (!busDominantIn [*5] |-> rxData)
    else $error("receive not high on recessive bus");
  tx_rec_a: assert property (txData [*5] |-> !busDriveDominant)
    else $error("bus driven while transmit high");
  tx_mode_a: assert property (busDriveDominant |-> !canWakeOnly)
    else $error("bus driven outside normal mode");
  uv_reset_a: assert property (
    (analogIn.mainUv && !lowPowerOscSel) [*5] |-> !resetOutN)
    else $error("reset high on undervoltage");
  shut_off_a: assert property (analogIn.tempShut [*5] |-> !mainRegEnable)
    else $error("regulator on in shutdown");
  sec_drive_a: assert property (secondary_reg_drive
    |-> !canWakeOnly && !lowPowerOscSel) else $error("secondary drive on");
  cs_idle_a: assert property (chipSelN [*4] |-> !misoOe)
    else $error("serial out driven while deselected");
endmodule
bind sbs_supervisor sbs_chk u_chk (
  .ref_clk, .rst, .psel, .penable, .paddr, .pready, .pslverr,
  .chipSelN, .misoOe, .txData, .busDominantIn, .rxData,
  .busDriveDominant, .canWakeOnly, .analogIn, .resetOutN,
  .mainRegEnable, .secondary_reg_drive, .lowPowerOscSel
);
`default_nettype wire

// file: tb/sbs_host_model.sv
// Host serial master that sends frames into the supervisor
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model (
  // Pacing clock
  input wire logic ref_clk,
  // Serial port
  output logic sclk,
  output logic chipSelN,
  output logic mosi,
  input wire logic miso
);
  // Idle: serial clock stands still low, device deselected
  initial
  begin
    sclk = 1'b0;
    chipSelN = 1'b1;
    mosi = 1'b0;
  end
  // Half period of four cycles gives a 200 ns serial clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    chipSelN <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      repeat (4) @(posedge ref_clk);
      rx[i] = miso;
      sclk <= 1'b1;
      mosi <= tx[i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    chipSelN <= 1'b1;
    mosi <= ~mosi; // Released line must not keep a stale bit
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the system basis supervisor
`timescale 1ns/1ps
`default_nettype none
`include "sbs_consts.svh"
`define CHK(n, e, g) cmp(n, 32'(e), 32'(g))
module tb;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} sbs_exp_s;
  // Port signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sclk, chipSelN, mosi, miso, misoOe, rxData;
  logic txData = 1'b1, busDominantIn = 1'b0, busDriveDominant;
  sbs_pkg::sbs_analog_s analogIn = '0;
  logic [3:0] level_inputs = 4'h0, lv;
  logic resetOutN, intOutN, watchdog_fault_out_n, mainRegEnable;
  logic canWakeOnly, secondary_reg_drive, high_side_switch, lowPowerOscSel;
  logic [7:0] rxByte;
  int errors = 0, checks = 0, n;
  sbs_exp_s expq[$];
  sbs_exp_s x;
  initial forever #12.5 ref_clk = ~ref_clk;
  // Short counts keep the run brief
  sbs_supervisor #(.NREQ_CYCLES(200), .RST_DUR_CYCLES(20),
    .WD_PERIOD_CYCLES(300), .CYC_PERIOD_CYCLES(50), .CYC_ON_CYCLES(5)) dut (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sclk, .chipSelN, .mosi, .miso, .misoOe, .txData,
    .rxData, .busDominantIn, .busDriveDominant, .canWakeOnly, .analogIn,
    .level_inputs, .resetOutN, .intOutN, .watchdog_fault_out_n,
    .mainRegEnable, .secondary_reg_drive, .high_side_switch,
    .lowPowerOscSel);
  sbs_host_model host (.ref_clk, .sclk, .chipSelN, .mosi, .miso);
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // One bus cycle; the expectation is queued for the monitor
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic er);
    expq.push_back('{d, m, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Monitor takes the oldest note at each completed transfer
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && expq.size() > 0)
    begin
      x = expq.pop_front();
      `CHK("prdata", x.d & x.m, prdata & x.m);
      `CHK("pslverr", x.e, pslverr);
    end
  task finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    errors++;
    finish_test;
  end
  initial
  begin
    void'($urandom(32'h90494A62));
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    apb(0, 12'h000, 32'h1, 32'h3F, 0);
    `CHK("resetOutN", 0, resetOutN);
    cyc(30);
    apb(0, 12'h000, 32'h2, 32'h3F, 0);
    `CHK("resetOutN", 1, resetOutN);
    analogIn.mainUv <= 1'b1;
    analogIn.tempShut <= 1'b1;
    cyc(8);
    `CHK("resetOutN", 0, resetOutN);
    `CHK("mainRegEnable", 0, mainRegEnable);
    analogIn <= '0;
    cyc(40);
    apb(1, 12'h004, 32'h0, 32'h0, 0);
    apb(0, 12'h000, 32'h4, 32'h3F, 0);
    repeat (8)
    begin
      txData <= 1'($urandom);
      busDominantIn <= 1'($urandom);
      cyc(6);
      `CHK("rxData", !busDominantIn, rxData);
      `CHK("busDrive", !txData, busDriveDominant);
    end
    apb(1, 12'h008, 32'hF, 32'h0, 0);
    analogIn.tempWarn <= 1'b1;
    cyc(8);
    `CHK("intOutN", 0, intOutN);
    apb(0, 12'h014, 32'h1, 32'h1, 0);
    analogIn.tempWarn <= 1'b0;
    analogIn.battery_fail_flag <= 1'b1;
    // Let the warning leave the synchroniser, else the set beats the clear
    cyc(4);
    apb(1, 12'h014, 32'h1, 32'h0, 0);
    cyc(4);
    `CHK("intOutN", 1, intOutN);
    analogIn.battery_fail_flag <= 1'b0;
    apb(0, 12'h014, 32'h10, 32'h10, 0);
    apb(1, 12'h004, 32'h0, 32'h0, 0);
    lv = 4'($urandom);
    level_inputs <= lv;
    analogIn <= 7'h07;
    cyc(6);
    apb(0, 12'h010, 32'({lv, 4'hE}), 32'hFF, 0);
    apb(0, 12'h014, 32'h6, 32'h6, 0);
    analogIn <= '0;
    cyc(4);
    apb(1, 12'h014, 32'h1F, 32'h0, 0);
    apb(0, 12'h018, 32'h0, 32'hFFFFFFFF, 1);
    apb(1, 12'h002, 32'h3, 32'h0, 1);
    apb(1, 12'h00C, 32'h1, 32'h0, 0);
    cyc(4);
    `CHK("hsSwitch", 1, high_side_switch);
    apb(1, 12'h004, 32'h0, 32'h0, 0);
    host.xfer(8'h11, rxByte);
    `CHK("misoFirst", 0, rxByte[7]);
    analogIn.hsOt <= 1'b1;
    cyc(6);
    apb(0, 12'h000, 32'h8, 32'h3F, 0);
    `CHK("secDrive", 0, secondary_reg_drive);
    `CHK("canWakeOnly", 1, canWakeOnly);
    `CHK("oscSel", 0, lowPowerOscSel);
    `CHK("hsSwitch", 1, high_side_switch);
    host.xfer(8'h12, rxByte);
    `CHK("misoByte", 8'h21, rxByte);
    analogIn.hsOt <= 1'b0;
    cyc(6);
    `CHK("oscSel", 1, lowPowerOscSel);
    level_inputs <= ~lv;
    n = 0;
    while (intOutN !== 1'b0 && n < 100)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    while (intOutN === 1'b0 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    `CHK("wakePulse", `SBS_WAKE_PULSE_CYCLES, n);
    n = 0;
    while (resetOutN !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    `CHK("resetOutN", 1, resetOutN);
    apb(1, 12'h004, 32'h0, 32'h0, 0);
    n = 0;
    while (watchdog_fault_out_n !== 1'b0 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    `CHK("wdFault", 0, watchdog_fault_out_n);
    finish_test;
  end
endmodule
`default_nettype wire
